// file: common/paged_cfg_cfg.svh
// Purpose: Offsets, reset values and access kinds of the page-0 bank
// Assumes: 7-bit register offset within a page, 8-bit registers
// Notes:   Kind codes: 0 unmapped, 1 read/write, 2 read-only, 3 special
`ifndef PAGED_CFG_CFG_SVH
`define PAGED_CFG_CFG_SVH

`define REG_W        8
`define OFS_W        7
`define PAGE_COUNT   128
`define K_NONE       2'h0
`define K_RW         2'h1
`define K_RO         2'h2
`define K_SPEC       2'h3
`define ZERO_BYTE    8'h00

// Page select and soft reset
`define OFS_PAGE     7'h00
`define RST_PAGE     8'h00
`define OFS_SRST     7'h01
`define RST_SRST     8'h00
`define SRST_BIT     0

// Read-only monitors
`define OFS_CLKMON   7'h15
`define RST_CLKMON   8'hFF
`define OFS_GPIOMON  7'h2A
`define RST_GPIOMON  8'h00
`define OFS_GPIMON   7'h2F
`define RST_GPIMON   8'h00
`define OFS_IRQLT    7'h36
`define RST_IRQLT    8'h00

// Read/write configuration registers
`define OFS_SLEEP    7'h02
`define RST_SLEEP    8'h00
`define OFS_SHDN     7'h05
`define RST_SHDN     8'h05
`define OFS_SPA      7'h07
`define RST_SPA      8'h30
`define OFS_SPB      7'h08
`define RST_SPB      8'h00
`define OFS_SPC      7'h09
`define RST_SPC      8'h00
`define OFS_SMIX     7'h0A
`define RST_SMIX     8'h00
`define OFS_SLOT1    7'h0B
`define RST_SLOT1    8'h00
`define OFS_SLOT2    7'h0C
`define RST_SLOT2    8'h01
`define OFS_SLOT3    7'h0D
`define RST_SLOT3    8'h02
`define OFS_SLOT4    7'h0E
`define RST_SLOT4    8'h03
`define OFS_CMA      7'h13
`define RST_CMA      8'h02
`define OFS_CMB      7'h14
`define RST_CMB      8'h48
`define OFS_CSRC     7'h16
`define RST_CSRC     8'h10
`define OFS_PDCLK    7'h1F
`define RST_PDCLK    8'h40
`define OFS_PDEDGE   7'h20
`define RST_PDEDGE   8'h00
`define OFS_GPCFG    7'h21
`define RST_GPCFG    8'h22
`define OFS_OPCFG    7'h22
`define RST_OPCFG    8'h00
`define OFS_OPVAL    7'h29
`define RST_OPVAL    8'h00
`define OFS_IPCFG    7'h2B
`define RST_IPCFG    8'h00
`define OFS_IRQCFG   7'h32
`define RST_IRQCFG   8'h00
`define OFS_IRQMSK   7'h33
`define RST_IRQMSK   8'hFF
`define OFS_CMTOL    7'h3A
`define RST_CMTOL    8'h00
`define OFS_BIAS     7'h3B
`define RST_BIAS     8'h00
`define OFS_C1A      7'h3C
`define RST_C1A      8'h00
`define OFS_C1B      7'h3D
`define RST_C1B      8'h00
`define OFS_C1C      7'h3E
`define RST_C1C      8'hC9
`define OFS_C1D      7'h3F
`define RST_C1D      8'h80
`define OFS_C1E      7'h40
`define RST_C1E      8'h00
`define OFS_C2A      7'h41
`define RST_C2A      8'h00
`define OFS_C2B      7'h42
`define RST_C2B      8'h00
`define OFS_C2C      7'h43
`define RST_C2C      8'hC9
`define OFS_C2D      7'h44
`define RST_C2D      8'h80
`define OFS_C2E      7'h45
`define RST_C2E      8'h00
`define OFS_C3C      7'h48
`define RST_C3C      8'hC9
`define OFS_C3D      7'h49
`define RST_C3D      8'h80
`define OFS_C3E      7'h4A
`define RST_C3E      8'h00
`define OFS_C4C      7'h4D
`define RST_C4C      8'hC9
`define OFS_C4D      7'h4E
`define RST_C4D      8'h80
`define OFS_C4E      7'h4F
`define RST_C4E      8'h00
`define OFS_SPRA     7'h6B
`define RST_SPRA     8'h01
`define OFS_SPRB     7'h6C
`define RST_SPRB     8'h40
`define OFS_RENH     7'h6D
`define RST_RENH     8'h7B

`endif

// file: common/paged_cfg_pkg.sv
// Purpose: Shared types of the paged configuration bank
// Assumes: Byte-wide registers
// Notes:   Constants live in paged_cfg_cfg.svh
package paged_cfg_pkg;
    typedef logic [7:0] reg_byte_type;
    typedef logic [6:0] reg_ofs_type;
    typedef logic [9:0] reg_info_type;
endpackage

// file: logic/paged_config_register_bank.sv
// Purpose: Page-0 configuration register bank with page select and soft reset
// Assumes: Byte register port driven by the serial control front end on clk_i
// Notes:   Read data appears one cycle after rd_en_i
`timescale 1ns/1ns
`default_nettype none
`include "paged_cfg_cfg.svh"

module paged_config_register_bank
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        wr_en_i,
    input  wire logic                        rd_en_i,
    input  wire paged_cfg_pkg::reg_ofs_type  addr_i,
    input  wire paged_cfg_pkg::reg_byte_type wdata_i,
    output var  paged_cfg_pkg::reg_byte_type rdata_o,
    output logic                             rvalid_o,
    input  wire paged_cfg_pkg::reg_byte_type clk_mon_i,
    input  wire paged_cfg_pkg::reg_byte_type general_pin_monitor_i,
    input  wire paged_cfg_pkg::reg_byte_type input_pin_monitor_i,
    input  wire paged_cfg_pkg::reg_byte_type irq_latch_i,
    input  wire paged_cfg_pkg::reg_ofs_type  cfg_sel_i,
    output var  paged_cfg_pkg::reg_byte_type cfg_val_o,
    output var  paged_cfg_pkg::reg_byte_type page_o,
    output logic                             soft_reset_o
);

    // ------------------------------------------------------------
    // Register table: access kind and default per offset
    // ------------------------------------------------------------
    function automatic paged_cfg_pkg::reg_info_type reg_info(input logic [6:0] a);
        case (a)
            `OFS_PAGE:    reg_info = {`K_SPEC, `RST_PAGE};
            `OFS_SRST:    reg_info = {`K_SPEC, `RST_SRST};
            // Power and sleep
            `OFS_SLEEP:   reg_info = {`K_RW, `RST_SLEEP};
            `OFS_SHDN:    reg_info = {`K_RW, `RST_SHDN};
            // Serial audio port and slot mapping
            `OFS_SPA:     reg_info = {`K_RW, `RST_SPA};
            `OFS_SPB:     reg_info = {`K_RW, `RST_SPB};
            `OFS_SPC:     reg_info = {`K_RW, `RST_SPC};
            `OFS_SMIX:    reg_info = {`K_RW, `RST_SMIX};
            `OFS_SLOT1:   reg_info = {`K_RW, `RST_SLOT1};
            `OFS_SLOT2:   reg_info = {`K_RW, `RST_SLOT2};
            `OFS_SLOT3:   reg_info = {`K_RW, `RST_SLOT3};
            `OFS_SLOT4:   reg_info = {`K_RW, `RST_SLOT4};
            // Clocking
            `OFS_CMA:     reg_info = {`K_RW, `RST_CMA};
            `OFS_CMB:     reg_info = {`K_RW, `RST_CMB};
            `OFS_CLKMON:  reg_info = {`K_RO, `RST_CLKMON};
            `OFS_CSRC:    reg_info = {`K_RW, `RST_CSRC};
            `OFS_PDCLK:   reg_info = {`K_RW, `RST_PDCLK};
            `OFS_PDEDGE:  reg_info = {`K_RW, `RST_PDEDGE};
            // General purpose pins
            `OFS_GPCFG:   reg_info = {`K_RW, `RST_GPCFG};
            `OFS_OPCFG:   reg_info = {`K_RW, `RST_OPCFG};
            `OFS_OPVAL:   reg_info = {`K_RW, `RST_OPVAL};
            `OFS_GPIOMON: reg_info = {`K_RO, `RST_GPIOMON};
            `OFS_IPCFG:   reg_info = {`K_RW, `RST_IPCFG};
            `OFS_GPIMON:  reg_info = {`K_RO, `RST_GPIMON};
            // Interrupt setup and readback
            `OFS_IRQCFG:  reg_info = {`K_RW, `RST_IRQCFG};
            `OFS_IRQMSK:  reg_info = {`K_RW, `RST_IRQMSK};
            `OFS_IRQLT:   reg_info = {`K_RO, `RST_IRQLT};
            // Converter front end
            `OFS_CMTOL:   reg_info = {`K_RW, `RST_CMTOL};
            `OFS_BIAS:    reg_info = {`K_RW, `RST_BIAS};
            // Per-channel settings
            `OFS_C1A:     reg_info = {`K_RW, `RST_C1A};
            `OFS_C1B:     reg_info = {`K_RW, `RST_C1B};
            `OFS_C1C:     reg_info = {`K_RW, `RST_C1C};
            `OFS_C1D:     reg_info = {`K_RW, `RST_C1D};
            `OFS_C1E:     reg_info = {`K_RW, `RST_C1E};
            `OFS_C2A:     reg_info = {`K_RW, `RST_C2A};
            `OFS_C2B:     reg_info = {`K_RW, `RST_C2B};
            `OFS_C2C:     reg_info = {`K_RW, `RST_C2C};
            `OFS_C2D:     reg_info = {`K_RW, `RST_C2D};
            `OFS_C2E:     reg_info = {`K_RW, `RST_C2E};
            `OFS_C3C:     reg_info = {`K_RW, `RST_C3C};
            `OFS_C3D:     reg_info = {`K_RW, `RST_C3D};
            `OFS_C3E:     reg_info = {`K_RW, `RST_C3E};
            `OFS_C4C:     reg_info = {`K_RW, `RST_C4C};
            `OFS_C4D:     reg_info = {`K_RW, `RST_C4D};
            `OFS_C4E:     reg_info = {`K_RW, `RST_C4E};
            // Signal processing
            `OFS_SPRA:    reg_info = {`K_RW, `RST_SPRA};
            `OFS_SPRB:    reg_info = {`K_RW, `RST_SPRB};
            `OFS_RENH:    reg_info = {`K_RW, `RST_RENH};
            // Reserved locations: no storage, read zero
            default:      reg_info = {`K_NONE, `ZERO_BYTE};
        endcase
    endfunction

    paged_cfg_pkg::reg_byte_type mem_r [0:`PAGE_COUNT-1];
    paged_cfg_pkg::reg_byte_type page_r;
    logic                        srst_r;
    logic                        clear_all;
    logic                        on_page0;
    logic                        wr_page0;

    // ------------------------------------------------------------
    // Soft reset request
    // ------------------------------------------------------------
    // Whole bank reloads one cycle after the request write, at the same edge
    // that the bit drops; writes landing in that reload cycle are lost.
    assign clear_all = rst_i | srst_r;
    assign on_page0  = (page_r == `RST_PAGE);
    assign wr_page0  = wr_en_i & on_page0 & ~srst_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            srst_r <= 1'b0;
        else if (srst_r)
            srst_r <= 1'b0;
        else if (wr_page0 && addr_i == `OFS_SRST)
            srst_r <= wdata_i[`SRST_BIT];
    end

    // ------------------------------------------------------------
    // Page select, reachable from every page
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (clear_all)
            page_r <= `RST_PAGE;
        else if (wr_en_i && addr_i == `OFS_PAGE)
            page_r <= wdata_i;
    end

    // ------------------------------------------------------------
    // Page-0 storage, one entry per offset
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PAGE_COUNT; gi++)
        begin : g_ent
            localparam paged_cfg_pkg::reg_info_type INFO = reg_info(7'(gi));
            if (INFO[9:8] == `K_RW)
            begin : g_rw
                always_ff @(posedge clk_i)
                begin
                    if (clear_all)
                        mem_r[gi] <= INFO[7:0];
                    else if (wr_page0 && addr_i == 7'(gi))
                        mem_r[gi] <= wdata_i;
                end
            end
            else if (INFO[9:8] == `K_RO)
            begin : g_ro
                paged_cfg_pkg::reg_byte_type src;
                always_comb
                begin
                    case (7'(gi))
                        `OFS_CLKMON:  src = clk_mon_i;
                        `OFS_GPIOMON: src = general_pin_monitor_i;
                        `OFS_GPIMON:  src = input_pin_monitor_i;
                        default:      src = irq_latch_i;
                    endcase
                end
                // Monitors show their default while the bank reloads
                always_ff @(posedge clk_i)
                begin
                    if (clear_all)
                        mem_r[gi] <= INFO[7:0];
                    else
                        mem_r[gi] <= src;
                end
            end
            else if (gi == `OFS_PAGE)
            begin : g_pg
                assign mem_r[gi] = page_r;
            end
            else if (gi == `OFS_SRST)
            begin : g_sr
                assign mem_r[gi] = {7'h00, srst_r};
            end
            else
            begin : g_none
                // Unmapped locations hold nothing and read zero
                assign mem_r[gi] = `ZERO_BYTE;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_o  <= `ZERO_BYTE;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= rd_en_i;
            if (rd_en_i)
            begin
                if (addr_i == `OFS_PAGE)
                    rdata_o <= page_r;
                else if (on_page0)
                    rdata_o <= mem_r[addr_i];
                else
                    rdata_o <= `ZERO_BYTE;
            end
        end
    end

    // ------------------------------------------------------------
    // Device-side view
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_val_o <= `ZERO_BYTE;
        else
            cfg_val_o <= mem_r[cfg_sel_i];
    end

    assign page_o       = page_r;
    assign soft_reset_o = srst_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    page_reset_a: assert property (srst_r |=> page_r == `RST_PAGE)
        else $error("page not restored by soft reset");
    page_write_a: assert property (wr_en_i && addr_i == `OFS_PAGE && !srst_r
        |=> page_r == $past(wdata_i)) else $error("page write lost");
    srst_set_a: assert property (wr_page0 && addr_i == `OFS_SRST
        |=> srst_r == $past(wdata_i[`SRST_BIT])) else $error("soft reset bit wrong");
    srst_clear_a: assert property (srst_r |=> !srst_r)
        else $error("soft reset bit stuck");
    rsvd_zero_a: assert property (mem_r[`OFS_SRST][7:1] == 7'h00)
        else $error("reserved bits nonzero");
    mask_default_a: assert property (srst_r |=> mem_r[`OFS_IRQMSK] == `RST_IRQMSK
        && mem_r[`OFS_C1C] == `RST_C1C) else $error("defaults not reloaded");
    chan_default_a: assert property (srst_r |=> mem_r[`OFS_C4C] == `RST_C4C
        && mem_r[`OFS_CMB] == `RST_CMB && mem_r[`OFS_RENH] == `RST_RENH)
        else $error("channel defaults not reloaded");
    // A foreign page has no storage, so the page-0 C1C entry must not move
    foreign_hold_a: assert property (wr_en_i && !on_page0 && !srst_r
        && addr_i != `OFS_PAGE |=> mem_r[`OFS_C1C] == $past(mem_r[`OFS_C1C]))
        else $error("write leaked into page 0");
    read_valid_a: assert property (rd_en_i |=> rvalid_o)
        else $error("read not answered");
    gap_zero_a: assert property (mem_r[7'h03] == `ZERO_BYTE)
        else $error("reserved location holds data");
    page_read_a: assert property (rd_en_i && addr_i == `OFS_PAGE
        |=> rvalid_o && rdata_o == $past(page_r)) else $error("page read wrong");
    other_page_a: assert property (rd_en_i && !on_page0 && addr_i != `OFS_PAGE
        |=> rdata_o == `ZERO_BYTE) else $error("foreign page read nonzero");
    zero_noop_a: assert property (wr_page0 && addr_i == `OFS_SRST
        && !wdata_i[`SRST_BIT] |=> !srst_r ##1 page_r == $past(page_r, 2))
        else $error("zero write reset the bank");

endmodule // paged_config_register_bank

`default_nettype wire

// file: verif/host_model.sv
// Purpose: Host side of the byte register port, in place of the serial front end
// Assumes: Requests change at the falling edge, are taken at the rising edge
// Notes:   Released address and data lines are inverted so stale values never match
`timescale 1ns/1ns
`default_nettype none
`include "paged_cfg_cfg.svh"
module host_model
(
    input  wire logic                        clk_i,
    output var  logic                        wr_en_o,
    output var  logic                        rd_en_o,
    output var  paged_cfg_pkg::reg_ofs_type  addr_o,
    output var  paged_cfg_pkg::reg_byte_type wdata_o,
    input  wire paged_cfg_pkg::reg_byte_type rdata_i,
    input  wire logic                        rvalid_i
);
    initial
    begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 7'h7F;
        wdata_o = 8'hA5;
    end
    task automatic put_byte(input paged_cfg_pkg::reg_ofs_type ofs,
                            input paged_cfg_pkg::reg_byte_type val);
        @(negedge clk_i);
        addr_o  = ofs;
        wdata_o = (ofs == `OFS_SRST) ? (val & 8'h01) : val;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o  = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
    // Read answer is fixed at one cycle; the valid pulse lasts one cycle only,
    // so it is taken in the half period right after the taking edge
    task automatic get_byte(input paged_cfg_pkg::reg_ofs_type ofs,
                            output paged_cfg_pkg::reg_byte_type val, output logic ok);
        @(negedge clk_i);
        addr_o  = ofs;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        val     = rdata_i;
        ok      = rvalid_i;
        rd_en_o = 1'b0;
        addr_o  = ~addr_o;
    endtask
endmodule // host_model
`default_nettype wire

// file: verif/testbench.sv
// Purpose: Self-checking bench for the paged configuration bank
// Assumes: 50 MHz clock, reset held 16 cycles
// Notes:   Only mapped page-0 offsets are ever written
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                        clk_i = 1'b0;
    logic                        rst_i, wr_en, rd_en, rvalid, soft_reset;
    paged_cfg_pkg::reg_ofs_type  addr, cfg_sel;
    paged_cfg_pkg::reg_byte_type wdata, rdata, cfg_val, page;
    paged_cfg_pkg::reg_byte_type clk_mon, general_pin_monitor, input_pin_monitor, irq_latch;
    int                          err_total = 0;
    int                          n_tests = 0;
    localparam paged_cfg_pkg::reg_ofs_type RW_OFS [15] = '{7'h02, 7'h05, 7'h07, 7'h0C,
        7'h13, 7'h14, 7'h16, 7'h1F, 7'h21, 7'h33, 7'h3E, 7'h3F, 7'h6B, 7'h6C, 7'h6D};
    localparam paged_cfg_pkg::reg_byte_type RW_DEF [15] = '{8'h00, 8'h05, 8'h30, 8'h01,
        8'h02, 8'h48, 8'h10, 8'h40, 8'h22, 8'hFF, 8'hC9, 8'h80, 8'h01, 8'h40, 8'h7B};
    always #10 clk_i = ~clk_i;
    host_model u_host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
    paged_config_register_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .clk_mon_i(clk_mon), .general_pin_monitor_i(general_pin_monitor), .input_pin_monitor_i(input_pin_monitor),
        .irq_latch_i(irq_latch), .cfg_sel_i(cfg_sel), .cfg_val_o(cfg_val), .page_o(page),
        .soft_reset_o(soft_reset));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input paged_cfg_pkg::reg_byte_type got, exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic rd_chk(input paged_cfg_pkg::reg_ofs_type ofs,
                          input paged_cfg_pkg::reg_byte_type exp);
        paged_cfg_pkg::reg_byte_type v;
        logic                        ok;
        u_host.get_byte(ofs, v, ok);
        check({7'h00, ok}, 8'h01);
        check(v, exp);
    endtask
    task automatic chk_defaults();
        rd_chk(7'h00, 8'h00);
        rd_chk(7'h01, 8'h00);
        check(page, 8'h00);
        for (int i = 0; i < 15; i++)
            rd_chk(RW_OFS[i], RW_DEF[i]);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        rst_i     = 1'b1;
        clk_mon   = 8'h5A;
        general_pin_monitor  = 8'h3C;
        input_pin_monitor   = 8'h96;
        irq_latch = 8'h21;
        cfg_sel   = 7'h3E;
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        chk_defaults();
        check(cfg_val, 8'hC9);
        rd_chk(7'h15, 8'h5A);
        rd_chk(7'h2A, 8'h3C);
        rd_chk(7'h2F, 8'h96);
        rd_chk(7'h36, 8'h21);
        rd_chk(7'h03, 8'h00);
        $display("test 1 done: power-on defaults");
        for (int i = 0; i < 15; i++)
            u_host.put_byte(RW_OFS[i], ~RW_DEF[i]);
        u_host.put_byte(7'h01, 8'h00);
        u_host.put_byte(7'h15, 8'h00);
        for (int i = 0; i < 15; i++)
            rd_chk(RW_OFS[i], ~RW_DEF[i]);
        rd_chk(7'h15, 8'h5A);
        check(cfg_val, 8'h36);
        $display("test 2 done: write, read back, zero to soft reset");
        u_host.put_byte(7'h00, 8'h07);
        check(page, 8'h07);
        u_host.put_byte(7'h00, 8'h00);
        u_host.put_byte(7'h01, 8'hFF);
        check({7'h00, soft_reset}, 8'h01);
        @(negedge clk_i);
        check({7'h00, soft_reset}, 8'h00);
        chk_defaults();
        check(cfg_val, 8'hC9);
        $display("test 3 done: soft reset reload");
        u_host.put_byte(7'h00, 8'hFF);
        check(page, 8'hFF);
        rd_chk(7'h00, 8'hFF);
        rd_chk(7'h3E, 8'h00);
        u_host.put_byte(7'h00, 8'h00);
        check(page, 8'h00);
        rd_chk(7'h3E, 8'hC9);
        $display("test 4 done: page switching");
        give_verdict();
    end
    // Whole run is well under 1000 cycles; five times that means a hang
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
